// file: hdl/gpc_pkg.sv
// package: constants for the gpio port and pad configuration block
package gpc_pkg;
  localparam int NUM_PINS = 12;
  localparam int PIN_FUNCTION_SELECT_W = 3;
  localparam int CUR_W = 4;
  localparam logic [2:0] PIN_FUNCTION_SELECT_GPIO = 3'h0;
  localparam logic [2:0] PIN_FUNCTION_SELECT_RESET = 3'h0;
  localparam logic [2:0] PIN_FUNCTION_SELECT_PERIPH_DFLT = 3'h1;
  // resistor mode encodings
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_PULLDOWN = 2'h1;
  localparam logic [1:0] MODE_PULLUP = 2'h2;
  localparam logic [1:0] MODE_REPEATER = 2'h3;
  localparam logic [1:0] MODE_RESET = 2'h0;
  // pins with their own defaults
  localparam int I2C_PAD_A = 4;
  localparam int I2C_PAD_B = 5;
  localparam int DEBUG_PAD_A = 10;
  localparam int DEBUG_PAD_B = 11;
  localparam logic [11:0] SPECIAL_PINS = 12'hC30;
  // high-drive pads
  localparam logic [11:0] HIGH_DRIVE_PINS = 12'hC88;
  // port access operations
  localparam logic [2:0] OP_WRITE = 3'h0;
  localparam logic [2:0] OP_MASKED = 3'h1;
  localparam logic [2:0] OP_SET = 3'h2;
  localparam logic [2:0] OP_CLEAR = 3'h3;
  localparam logic [2:0] OP_DIR_WRITE = 3'h4;
  localparam logic [2:0] OP_DIR_SET = 3'h5;
  localparam logic [2:0] OP_DIR_CLEAR = 3'h6;
  localparam logic [2:0] OP_DIR_TOGGLE = 3'h7;
  localparam int START_IRQ_W = 13;
  localparam int PORT_IRQ_LINE = 31;
endpackage

// file: hdl/gpc_port.sv
// gpio port with per-pin pad configuration
`timescale 1ns/1ps
// How it works
// - function code zero selects port logic
// - gpio pins follow the direction bit
// - peripheral pins take peripheral direction
// - per-pin resistor mode, four settings
// - resistor mode resets to no pull
// - repeater pulls toward last read level
// - repeater retention dropped in deep power-down
// - i2c pads: filtered or plain open-drain
// - high-drive pads digital or current sink
// - sink mode switches between low/high levels
// - whole-port single write of outputs
// - masked, set-only and clear-only writes
// - single-cycle io bus access
// - reset gives gpio inputs, special pins excepted
// - direction bits set, clear, toggle individually
// - each port bit fixed to one pin
// - combined port interrupt on line 31
// - pins 0..10 drive start interrupts 0..10
// - start 11 nfc access, 12 on/off timer
module gpc_port #(
  parameter int NUM_PINS = gpc_pkg::NUM_PINS,
  parameter int FLT_LEN = 3
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // single-cycle io bus
  input wire logic busValid,
  input wire logic [2:0] busOp,
  input wire logic [NUM_PINS-1:0] busWdata,
  input wire logic [NUM_PINS-1:0] busMask,
  output logic [NUM_PINS-1:0] busRdata,
  output logic [NUM_PINS-1:0] busDirRdata,
  output logic busReady,
  // pad configuration write
  input wire logic cfgWrite,
  input wire logic [3:0] cfgPin,
  input wire logic [2:0] cfgFunc,
  input wire logic [1:0] cfgMode,
  input wire logic cfgI2cPlain,
  input wire logic cfgSinkMode,
  input wire logic [3:0] cfgLowCur,
  input wire logic [3:0] cfgHighCur,
  // peripheral side
  input wire logic [NUM_PINS-1:0] periphOut,
  input wire logic [NUM_PINS-1:0] periphOe,
  output logic [NUM_PINS-1:0] periphIn,
  // pads
  input wire logic [NUM_PINS-1:0] padIn,
  output logic [NUM_PINS-1:0] padOut,
  output logic [NUM_PINS-1:0] padOe,
  output logic [NUM_PINS-1:0] padPullUp,
  output logic [NUM_PINS-1:0] padPullDown,
  output logic [NUM_PINS-1:0] padSinkEn,
  output logic [NUM_PINS*4-1:0] padSinkLevel,
  // power state and events
  input wire logic deepPowerDown,
  input wire logic [NUM_PINS-1:0] portIrqStatus,
  input wire logic nfcAccess,
  input wire logic onOffTimerEvent,
  output logic [12:0] startIrq,
  output logic [31:0] nvicIrq
);
  // port state
  logic [NUM_PINS-1:0] outData_q, outData_d;
  logic [NUM_PINS-1:0] dir_q, dir_d;
  logic [NUM_PINS-1:0] rdata_d, dirRd_d;
  logic busReady_d;

  // pad configuration state, one entry per pin
  logic [2:0] pin_function_select_q [NUM_PINS];
  logic [2:0] pin_function_select_d [NUM_PINS];
  logic [1:0] mode_q [NUM_PINS];
  logic [1:0] mode_d [NUM_PINS];
  logic [3:0] lowCur_q [NUM_PINS];
  logic [3:0] lowCur_d [NUM_PINS];
  logic [3:0] highCur_q [NUM_PINS];
  logic [3:0] highCur_d [NUM_PINS];
  logic [NUM_PINS-1:0] i2cPlain_q, i2cPlain_d;
  logic [NUM_PINS-1:0] sink_q, sink_d;

  // input sampling: glitch filter and repeater level
  logic [FLT_LEN-1:0] flt_q [NUM_PINS];
  logic [FLT_LEN-1:0] flt_d [NUM_PINS];
  logic [NUM_PINS-1:0] fltOut_q, fltOut_d;
  logic [NUM_PINS-1:0] pinIn_q, pinIn_d;

  // pad and peripheral output next values
  logic [NUM_PINS-1:0] padOut_d, padOe_d;
  logic [NUM_PINS-1:0] pu_d, pd_d;
  logic [NUM_PINS-1:0] sinkEn_d, periphIn_d;
  logic [NUM_PINS*4-1:0] sinkLvl_d;

  // interrupt next values
  logic [12:0] startIrq_d;
  logic [31:0] nvicIrq_d;

  function automatic logic isI2c(input int p);
    isI2c = (p == gpc_pkg::I2C_PAD_A) || (p == gpc_pkg::I2C_PAD_B);
  endfunction

  // port data and direction operations
  always_comb begin
    outData_d = outData_q;
    dir_d = dir_q;
    if (busValid) begin
      unique case (busOp)
        gpc_pkg::OP_WRITE: outData_d = busWdata;
        gpc_pkg::OP_MASKED: outData_d = (outData_q & ~busMask) | (busWdata & busMask);
        gpc_pkg::OP_SET: outData_d = outData_q | busWdata;
        gpc_pkg::OP_CLEAR: outData_d = outData_q & ~busWdata;
        gpc_pkg::OP_DIR_WRITE: dir_d = busWdata;
        gpc_pkg::OP_DIR_SET: dir_d = dir_q | busWdata;
        gpc_pkg::OP_DIR_CLEAR: dir_d = dir_q & ~busWdata;
        gpc_pkg::OP_DIR_TOGGLE: dir_d = dir_q ^ busWdata;
      endcase
    end
    // read-back: pins as sampled, direction after this access
    rdata_d = padIn;
    dirRd_d = dir_d;
    busReady_d = busValid;
  end

  // pad configuration writes; fields a pin lacks keep their reset value
  always_comb begin
    i2cPlain_d = i2cPlain_q;
    sink_d = sink_q;
    for (int p = 0; p < NUM_PINS; p++) begin
      pin_function_select_d[p] = pin_function_select_q[p];
      mode_d[p] = mode_q[p];
      lowCur_d[p] = lowCur_q[p];
      highCur_d[p] = highCur_q[p];
      // a pin index past the port matches no pin and is dropped
      if (cfgWrite && cfgPin == 4'(p)) begin
        pin_function_select_d[p] = cfgFunc;
        mode_d[p] = cfgMode;
        if (isI2c(p)) i2cPlain_d[p] = cfgI2cPlain;
        if (gpc_pkg::HIGH_DRIVE_PINS[p]) begin
          sink_d[p] = cfgSinkMode;
          lowCur_d[p] = cfgLowCur;
          highCur_d[p] = cfgHighCur;
        end
      end
    end
  end

  // input glitch filter: the filtered level changes only after a stable run
  always_comb begin
    fltOut_d = fltOut_q;
    pinIn_d = padIn;
    for (int p = 0; p < NUM_PINS; p++) begin
      flt_d[p] = {flt_q[p][FLT_LEN-2:0], padIn[p]};
      if (&flt_q[p]) fltOut_d[p] = 1'b1;
      else if (~|flt_q[p]) fltOut_d[p] = 1'b0;
    end
  end

  // pad drive, pulls and peripheral muxing
  always_comb begin
    logic gpio, odPin, drv, oe;
    gpio = 1'b0;
    odPin = 1'b0;
    drv = 1'b0;
    oe = 1'b0;
    for (int p = 0; p < NUM_PINS; p++) begin
      gpio = (pin_function_select_q[p] == gpc_pkg::PIN_FUNCTION_SELECT_GPIO);
      odPin = !gpio && isI2c(p);
      drv = gpio ? outData_q[p] : periphOut[p];
      oe = gpio ? dir_q[p] : periphOe[p];
      // i2c function drives open-drain: only low is driven
      if (odPin) begin
        oe = oe && !drv;
        drv = 1'b0;
      end
      // a sink pad stops driving voltage; the sink current takes over
      sinkEn_d[p] = sink_q[p] && oe;
      sinkLvl_d[p*4 +: 4] = drv ? highCur_q[p] : lowCur_q[p];
      padOut_d[p] = drv;
      padOe_d[p] = oe && !sink_q[p];
      // each index stays on its own pad
      // gpio pins hide their level from the peripheral
      periphIn_d[p] = gpio ? 1'b0 : ((odPin && !i2cPlain_q[p]) ? fltOut_q[p] : padIn[p]);
      unique case (mode_q[p])
        gpc_pkg::MODE_PULLUP: begin
          pu_d[p] = 1'b1;
          pd_d[p] = 1'b0;
        end
        gpc_pkg::MODE_PULLDOWN: begin
          pu_d[p] = 1'b0;
          pd_d[p] = 1'b1;
        end
        gpc_pkg::MODE_REPEATER: begin
          pu_d[p] = !deepPowerDown && pinIn_q[p];
          pd_d[p] = !deepPowerDown && !pinIn_q[p];
        end
        gpc_pkg::MODE_NONE: begin
          pu_d[p] = 1'b0;
          pd_d[p] = 1'b0;
        end
      endcase
    end
  end

  // interrupt routing
  always_comb begin
    // start lines carry raw pin levels; sensing is up to the start logic
    startIrq_d = '0;
    startIrq_d[10:0] = padIn[10:0];
    startIrq_d[11] = nfcAccess;
    startIrq_d[12] = onOffTimerEvent;
    nvicIrq_d = '0;
    nvicIrq_d[12:0] = startIrq_d;
    nvicIrq_d[gpc_pkg::PORT_IRQ_LINE] = |portIrqStatus;
  end

  // port state and bus answer registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      // direction resets to input so no gpio-function pad is driven before software asks
      outData_q <= '0;
      dir_q <= '0;
      busRdata <= '0;
      busDirRdata <= '0;
      busReady <= 1'b0;
    end else begin
      outData_q <= outData_d;
      dir_q <= dir_d;
      busRdata <= rdata_d;
      busDirRdata <= dirRd_d;
      busReady <= busReady_d;
    end
  end

  // pad configuration registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      i2cPlain_q <= '0;
      sink_q <= '0;
      for (int p = 0; p < NUM_PINS; p++) begin
        pin_function_select_q[p] <= gpc_pkg::SPECIAL_PINS[p] ? gpc_pkg::PIN_FUNCTION_SELECT_PERIPH_DFLT : gpc_pkg::PIN_FUNCTION_SELECT_RESET;
        mode_q[p] <= gpc_pkg::MODE_RESET;
        lowCur_q[p] <= '0;
        highCur_q[p] <= '0;
      end
    end else begin
      i2cPlain_q <= i2cPlain_d;
      sink_q <= sink_d;
      pin_function_select_q <= pin_function_select_d;
      mode_q <= mode_d;
      lowCur_q <= lowCur_d;
      highCur_q <= highCur_d;
    end
  end

  // input sampling registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      // filter starts full of ones so the i2c lines look released after reset
      pinIn_q <= '0;
      fltOut_q <= '1;
      for (int p = 0; p < NUM_PINS; p++) begin
        flt_q[p] <= '1;
      end
    end else begin
      pinIn_q <= pinIn_d;
      fltOut_q <= fltOut_d;
      flt_q <= flt_d;
    end
  end

  // pad and peripheral outputs launch from flops so pads see no decode glitches
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      padOut <= '0;
      padOe <= '0;
      padPullUp <= '0;
      padPullDown <= '0;
      padSinkEn <= '0;
      padSinkLevel <= '0;
      periphIn <= '0;
    end else begin
      padOut <= padOut_d;
      padOe <= padOe_d;
      padPullUp <= pu_d;
      padPullDown <= pd_d;
      padSinkEn <= sinkEn_d;
      padSinkLevel <= sinkLvl_d;
      periphIn <= periphIn_d;
    end
  end

  // interrupt line registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      startIrq <= '0;
      nvicIrq <= '0;
    end else begin
      startIrq <= startIrq_d;
      nvicIrq <= nvicIrq_d;
    end
  end
endmodule

// file: bench/gpc_port_checker.sv
// assertions on the gpio port block ports
`timescale 1ns/1ps
module gpc_port_checker #(
  parameter int NUM_PINS = 12
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // io bus
  input wire logic busValid,
  input wire logic [2:0] busOp,
  input wire logic [NUM_PINS-1:0] busWdata,
  input wire logic [NUM_PINS-1:0] busRdata,
  input wire logic [NUM_PINS-1:0] busDirRdata,
  input wire logic busReady,
  // pins and events
  input wire logic [NUM_PINS-1:0] padIn,
  input wire logic [NUM_PINS-1:0] portIrqStatus,
  input wire logic nfcAccess,
  input wire logic onOffTimerEvent,
  input wire logic [12:0] startIrq,
  input wire logic [31:0] nvicIrq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_tglReq; busValid && busOp == gpc_pkg::OP_DIR_TOGGLE; endsequence
  sequence s_setReq; busValid && busOp == gpc_pkg::OP_DIR_SET; endsequence
  property p_ready; $past(resetn) |-> busReady == $past(busValid); endproperty
  property p_rdata; $past(resetn) |-> busRdata == $past(padIn); endproperty
  property p_pinIrq; $past(resetn) |-> startIrq[10:0] == $past(padIn[10:0]); endproperty
  property p_evtIrq; $past(resetn) |-> startIrq[12:11] == {$past(onOffTimerEvent), $past(nfcAccess)}; endproperty
  property p_portIrq; $past(resetn) |-> nvicIrq[31] == |$past(portIrqStatus); endproperty
  property p_tgl; s_tglReq |=> busDirRdata == ($past(busDirRdata) ^ $past(busWdata)); endproperty
  property p_set; s_setReq |=> busDirRdata == ($past(busDirRdata) | $past(busWdata)); endproperty
  property p_hold; !(busValid && busOp[2]) |=> $stable(busDirRdata); endproperty
  a_ready: assert property (p_ready) else $error("ready not one cycle after access");
  a_rdata: assert property (p_rdata) else $error("read data not pin level");
  a_pinIrq: assert property (p_pinIrq) else $error("start irq not pin level");
  a_evtIrq: assert property (p_evtIrq) else $error("start irq 11 or 12 wrong");
  a_portIrq: assert property (p_portIrq) else $error("line 31 not port status");
  a_tgl: assert property (p_tgl) else $error("direction toggle wrong");
  a_set: assert property (p_set) else $error("direction set wrong");
  a_hold: assert property (p_hold) else $error("direction changed without access");
endmodule
bind gpc_port gpc_port_checker #(.NUM_PINS(NUM_PINS)) i_chk (.*);

// file: bench/gpc_pad_model.sv
// external circuitry seen by the twelve pads
`timescale 1ns/1ps
module gpc_pad_model (
  // clock
  input wire logic core_clk,
  // pad side of the block
  input wire logic [11:0] padOut,
  input wire logic [11:0] padOe,
  input wire logic [11:0] padPullUp,
  input wire logic [11:0] padPullDown,
  // external drivers
  input wire logic [11:0] extVal,
  input wire logic [11:0] extEn,
  output logic [11:0] padIn
);
  logic [11:0] lastQ = 12'h000;
  // a pad nobody drives or pulls shows a changing level, never a stale one
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      if (padOe[i]) padIn[i] = padOut[i];
      else if (extEn[i]) padIn[i] = extVal[i];
      else if (padPullUp[i] | padPullDown[i]) padIn[i] = padPullUp[i];
      else padIn[i] = ~lastQ[i];
    end
  end
  always @(posedge core_clk) lastQ <= padIn;
endmodule

// file: bench/tb_top.sv
// self-checking bench for the gpio port block
`timescale 1ns/1ps
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin errCount++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic core_clk = 1'b0, resetn = 1'b0, busValid = 1'b0, cfgWrite = 1'b0, cfgI2cPlain = 1'b0, cfgSinkMode = 1'b0;
  logic deepPowerDown = 1'b0, nfcAccess = 1'b0, onOffTimerEvent = 1'b0, busReady;
  logic [1:0] cfgMode = 2'h0;
  logic [2:0] busOp = 3'h0, cfgFunc = 3'h0;
  logic [3:0] cfgPin = 4'h0, cfgLowCur = 4'h5, cfgHighCur = 4'hA;
  logic [11:0] busWdata = 12'h000, busMask = 12'h000, periphOut = 12'h000, periphOe = 12'h000, portIrqStatus = 12'h000;
  logic [11:0] extVal = 12'h000, extEn = 12'h000, outQ = 12'h000, dirQ = 12'h000, gp = 12'h3CB;
  logic [11:0] busRdata, busDirRdata, periphIn, padIn, padOut, padOe, padPullUp, padPullDown, padSinkEn;
  logic [12:0] startIrq;
  logic [31:0] nvicIrq, seed = 32'h0EC1274B;
  logic [47:0] padSinkLevel;
  int errCount = 0, checksDone = 0;
  gpc_port i_dut (.*);
  gpc_pad_model i_pads (.*);
  always #2 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [11:0] applyOp(input logic [2:0] op, input logic [11:0] q, w, m);
    case (op)
      3'h1: return (q & ~m) | (w & m);
      3'h2, 3'h5: return q | w;
      3'h3, 3'h6: return q & ~w;
      3'h7: return q ^ w;
      default: return w;
    endcase
  endfunction
  task automatic doOp(input logic [2:0] op, input logic [11:0] w, m);
    @(negedge core_clk);
    {busValid, busOp, busWdata, busMask} = {1'b1, op, w, m};
    if (op[2]) dirQ = applyOp(op, dirQ, w, m);
    else outQ = applyOp(op, outQ, w, m);
    @(negedge core_clk);
    busValid = 1'b0;
    `CHK(busReady, 1'b1)
    `CHK(busDirRdata, dirQ)
    @(negedge core_clk);
    `CHK(padOe & gp, dirQ & gp)
    `CHK(padOut & dirQ & gp, outQ & dirQ & gp)
    `CHK({padOe[2], padOut[2]}, {periphOe[2], periphOut[2]})
    `CHK(periphIn & gp, 12'h000)
  endtask
  task automatic cfg(input logic [3:0] p, input logic [2:0] f, input logic [1:0] md, input logic sk);
    @(negedge core_clk);
    {cfgWrite, cfgPin, cfgFunc, cfgMode, cfgSinkMode} = {1'b1, p, f, md, sk};
    @(negedge core_clk);
    cfgWrite = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic giveVerdict;
    $display("comparisons %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #20000;
    errCount++;
    giveVerdict();
  end
  initial begin
    repeat (20) @(negedge core_clk);
    resetn = 1'b1;
    @(negedge core_clk);
    `CHK({busDirRdata, padOe, padSinkEn}, 36'h0)
    `CHK(padPullUp | padPullDown, 12'h000)
    $display("reset test done");
    cfg(4'h2, gpc_pkg::PIN_FUNCTION_SELECT_PERIPH_DFLT, gpc_pkg::MODE_NONE, 1'b0);
    for (int i = 0; i < 8; i++) doOp(3'(i), 12'hA5A, 12'h0F0);
    doOp(gpc_pkg::OP_DIR_WRITE, 12'hFFF, 12'h000);
    doOp(gpc_pkg::OP_WRITE, 12'h001, 12'h000);
    `CHK(padOut & gp, 12'h001)
    doOp(gpc_pkg::OP_WRITE, 12'h5A5, 12'h000);
    `CHK(padOut & padOe & gp, 12'h5A5 & gp)
    repeat (150) begin
      seed = lfsr(seed);
      {periphOe, periphOut, extEn} = {seed, seed[3:0]};
      {extVal, portIrqStatus, nfcAccess, onOffTimerEvent} = seed[31:6];
      seed = lfsr(seed);
      doOp(seed[2:0], seed[14:3], seed[26:15]);
    end
    $display("port access test done");
    doOp(gpc_pkg::OP_DIR_CLEAR, 12'h040, 12'h000);
    {extEn, extVal} = {12'h040, 12'hFFF};
    for (int m = 0; m < 4; m++) begin
      cfg(4'h6, gpc_pkg::PIN_FUNCTION_SELECT_GPIO, 2'(m), 1'b0);
      `CHK({padPullUp[6], padPullDown[6]}, {1'(m > 1), 1'(m == 1)})
    end
    extVal = 12'h000;
    repeat (3) @(negedge core_clk);
    `CHK({padPullUp[6], padPullDown[6]}, 2'b01)
    deepPowerDown = 1'b1;
    repeat (3) @(negedge core_clk);
    `CHK({padPullUp[6], padPullDown[6]}, 2'b00)
    deepPowerDown = 1'b0;
    $display("resistor test done");
    gp = 12'h3C3;
    cfg(4'h3, gpc_pkg::PIN_FUNCTION_SELECT_GPIO, gpc_pkg::MODE_NONE, 1'b1);
    cfg(4'h6, gpc_pkg::PIN_FUNCTION_SELECT_GPIO, gpc_pkg::MODE_NONE, 1'b1);
    doOp(gpc_pkg::OP_DIR_SET, 12'h048, 12'h000);
    `CHK({padSinkEn[6], padOe[6]}, 2'b01)
    doOp(gpc_pkg::OP_SET, 12'h008, 12'h000);
    `CHK({padSinkEn[3], padOe[3], padSinkLevel[15:12]}, 6'h2A)
    doOp(gpc_pkg::OP_CLEAR, 12'h008, 12'h000);
    `CHK(padSinkLevel[15:12], 4'h5)
    $display("sink test done");
    {periphOe, periphOut, extEn, extVal} = {12'h010, 12'h000, 12'h000, 12'h000};
    repeat (2) @(negedge core_clk);
    `CHK({padOe[4], padOut[4]}, 2'b10)
    periphOut = 12'h010;
    repeat (2) @(negedge core_clk);
    `CHK(padOe[4], 1'b0)
    {periphOe, extEn} = {12'h000, 12'h010};
    repeat (6) @(negedge core_clk);
    `CHK(periphIn[4], 1'b0)
    extVal = 12'h010;
    @(negedge core_clk);
    extVal = 12'h000;
    repeat (4) begin
      @(negedge core_clk);
      `CHK(periphIn[4], 1'b0)
    end
    extVal = 12'h010;
    repeat (6) @(negedge core_clk);
    `CHK(periphIn[4], 1'b1)
    cfgI2cPlain = 1'b1;
    cfg(4'h4, gpc_pkg::PIN_FUNCTION_SELECT_PERIPH_DFLT, gpc_pkg::MODE_NONE, 1'b0);
    extVal = 12'h000;
    @(negedge core_clk);
    `CHK(periphIn[4], 1'b0)
    extVal = 12'h010;
    @(negedge core_clk);
    extVal = 12'h000;
    `CHK(periphIn[4], 1'b1)
    $display("i2c pad test done");
    giveVerdict();
  end
endmodule
